// [hdl/bfd_bit_placer.sv]
// Packs received bits into FIFO bytes starting at a chosen bit position
`timescale 1ns/1ps
`include "bfd_cfg.svh"

module bfd_bit_placer (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [2:0]            align,
    input  wire bfd_pkg::bfd_rx_bit_t  rx_in,
    output bfd_pkg::bfd_fifo_wr_t      fifo_wr,
    output logic                       done
);
    import bfd_pkg::*;

    logic       active;
    logic [2:0] pos;
    logic [7:0] acc;
    logic       have_bits;
    logic [2:0] cur_pos;
    logic [7:0] merged;
    logic       byte_full;

    // Alignment is taken only at the first bit of a frame
    always_comb
    begin
        cur_pos   = active ? pos : align;                                 // R01
        merged    = acc;
        byte_full = 1'b0;
        if (rx_in.valid)
        begin
            merged[cur_pos] = rx_in.data;                                 // R01
            byte_full       = (cur_pos == 3'h7);                          // R02
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active    <= 1'b0;
            pos       <= 3'h0;
            acc       <= 8'h00;
            have_bits <= 1'b0;
        end
        else if (rx_in.frame_end)
        begin
            active    <= 1'b0;
            pos       <= 3'h0;
            acc       <= 8'h00;
            have_bits <= 1'b0;
        end
        else if (rx_in.valid)
        begin
            active    <= 1'b1;
            pos       <= cur_pos + 3'h1;                                  // R02
            acc       <= byte_full ? 8'h00 : merged;
            have_bits <= !byte_full;
        end
    end

    // A partial byte is flushed at frame end; its unused bits stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_wr <= '0;
            done    <= 1'b0;
        end
        else
        begin
            fifo_wr.valid <= byte_full ||
                             (rx_in.frame_end && (have_bits || rx_in.valid));
            fifo_wr.data  <= merged;
            done          <= rx_in.frame_end && (active || rx_in.valid);
        end
    end

endmodule : bfd_bit_placer

// [hdl/bfd_cfg.svh]
// Offsets, field positions, reset values and counts for the framing/driver block
`ifndef BFD_CFG_SVH
`define BFD_CFG_SVH

`define BFD_IDX_FRAME           8'h0f
`define BFD_IDX_DRIVER          8'h11
`define BFD_ADDR_FRAME          {`BFD_IDX_FRAME, 2'b00}
`define BFD_ADDR_DRIVER         {`BFD_IDX_DRIVER, 2'b00}
`define BFD_ADDR_W              10

`define BFD_FRAME_RESET         8'h00
`define BFD_DRIVER_RESET        8'h58

`define BFD_ALIGN_HI            6
`define BFD_ALIGN_LO            4
`define BFD_LAST_HI             2
`define BFD_LAST_LO             0
`define BFD_MODSEL_HI           6
`define BFD_MODSEL_LO           5
`define BFD_INV_BIT             3
`define BFD_STEADY_BIT          2
`define BFD_RF2_BIT             1
`define BFD_RF1_BIT             0
`define BFD_CTL_ZERO_BIT        7
`define BFD_CTL_ONE_BIT         4

`define BFD_FULL_BYTE_BITS      4'h8
`define BFD_IDLE_LEVEL          1'b0

`endif

// [hdl/bfd_pkg.sv]
// Types shared by the framing/driver block
package bfd_pkg;

    typedef enum logic [1:0] {
        BFD_MOD_LOW      = 2'b00,
        BFD_MOD_HIGH     = 2'b01,
        BFD_MOD_CODER    = 2'b10,
        BFD_MOD_EXTERNAL = 2'b11
    } bfd_mod_sel_t;

    typedef enum logic [0:0] {
        BFD_TX_IDLE  = 1'b0,
        BFD_TX_SHIFT = 1'b1
    } bfd_tx_state_t;

    typedef struct packed {
        logic [2:0] rx_first_bit_position;
        logic [2:0] tx_final_byte_bit_count;
    } bfd_frame_t;

    typedef struct packed {
        logic         ctl_bit7;
        bfd_mod_sel_t modulation_input_select;
        logic         ctl_bit4;
        logic         second_driver_invert;
        logic         second_driver_steady_carrier;
        logic         second_driver_rf_on;
        logic         first_driver_rf_on;
    } bfd_driver_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } bfd_tx_byte_t;

    typedef struct packed {
        logic valid;
        logic data;
        logic frame_end;
    } bfd_rx_bit_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bfd_fifo_wr_t;

endpackage : bfd_pkg

// [hdl/bfd_top.sv]
// Bit-framing and antenna driver control with APB register access
//
// Functional notes
// R01: Receive alignment bits 6-4 pick FIFO bit for first received bit.
// R02: Alignment 7 puts first bit at bit 7, next at bit 0 of next byte.
// R03: Last-bits field 2-0 gives bits sent of final byte; 0 means eight.
// R04: Hardware clears last-bits after transmit and alignment after receive.
// R05: Framing register resets to zero; bits 7 and 3 stay zero.
// R06: Modulation select bits 6-5: low, high, internal coder, external pin.
// R07: Invert bit 3 makes second driver output inverted carrier.
// R08: Steady-carrier bit 2 gives unmodulated carrier on second driver.
// R09: RF-on bit 1 enables modulated carrier on second driver, else constant.
// R10: RF-on bit 0 enables modulated carrier on first driver, else constant.
// R11: Software keeps control bit 7 at 0 and bit 4 at 1; reset 0x58.
// R12: Self-cleared fields stay software writable; hardware clear wins.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "bfd_cfg.svh"

module bfd_top (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire bfd_pkg::bfd_tx_byte_t     tx_byte,
    output logic                           tx_byte_ready,
    input  wire logic                      tx_bit_tick,
    output logic                           tx_done,
    input  wire bfd_pkg::bfd_rx_bit_t      rx_bit,
    output bfd_pkg::bfd_fifo_wr_t          fifo_wr,
    output logic                           rx_done,
    input  wire logic                      carrier_in,
    input  wire logic                      external_modulation_pin,
    output logic                           first_antenna_driver,
    output logic                           second_antenna_driver
);
    import bfd_pkg::*;

    bfd_frame_t    frame;
    bfd_driver_t   driver;
    bfd_tx_state_t tx_state;
    bfd_tx_state_t next_tx_state;

    logic          setup_phase;
    logic          access_phase;
    logic          hit_frame;
    logic          hit_driver;
    logic          mapped;
    logic          wr_frame;
    logic          wr_driver;
    logic          rx_clear;

    logic [7:0]    shift;
    logic [3:0]    bits_left;
    logic          last_byte;
    logic          coder_bit;
    logic [3:0]    final_bits;
    logic          tx_end;

    logic          mod_in;
    logic          rf_burst;
    logic          second_base;

    // APB decode; word index is the printed offset, byte address four times it
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign hit_frame    = (paddr[`BFD_ADDR_W-1:0] == `BFD_ADDR_FRAME) &&
                          (paddr[31:`BFD_ADDR_W] == '0);
    assign hit_driver   = (paddr[`BFD_ADDR_W-1:0] == `BFD_ADDR_DRIVER) &&
                          (paddr[31:`BFD_ADDR_W] == '0);
    assign mapped       = hit_frame || hit_driver;
    assign wr_frame     = access_phase && pwrite && hit_frame;
    assign wr_driver    = access_phase && pwrite && hit_driver;

    // Zero wait states; unmapped addresses answer with an error
    assign pready       = 1'b1;
    assign pslverr      = access_phase && !mapped;

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase && !pwrite)
        begin
            if (hit_frame)
            begin
                prdata <= {24'h00_0000, 1'b0, frame.rx_first_bit_position,
                           1'b0, frame.tx_final_byte_bit_count};          // R05
            end
            else if (hit_driver)
            begin
                prdata <= {24'h00_0000, driver};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Framing register; reserved bits are not stored so they always read zero
    // Hardware clears are tested first, so they beat a same-cycle write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame <= '0;                                                  // R05
        end
        else
        begin
            if (tx_end)
            begin
                frame.tx_final_byte_bit_count <= 3'h0;                    // R04 R12
            end
            else if (wr_frame)
            begin
                frame.tx_final_byte_bit_count <= pwdata[`BFD_LAST_HI:`BFD_LAST_LO];
            end
            if (rx_clear)
            begin
                frame.rx_first_bit_position <= 3'h0;                      // R04 R12
            end
            else if (wr_frame)
            begin
                frame.rx_first_bit_position <= pwdata[`BFD_ALIGN_HI:`BFD_ALIGN_LO];
            end
        end
    end

    // Driver control; bits 7 and 4 are stored as written, software keeps them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            driver <= bfd_driver_t'(`BFD_DRIVER_RESET);                   // R11
        end
        else if (wr_driver)
        begin
            driver.ctl_bit7                     <= pwdata[`BFD_CTL_ZERO_BIT];
            driver.modulation_input_select      <=
                bfd_mod_sel_t'(pwdata[`BFD_MODSEL_HI:`BFD_MODSEL_LO]);  // R06
            driver.ctl_bit4                     <= pwdata[`BFD_CTL_ONE_BIT];
            driver.second_driver_invert         <= pwdata[`BFD_INV_BIT];     // R07
            driver.second_driver_steady_carrier <= pwdata[`BFD_STEADY_BIT];  // R08
            driver.second_driver_rf_on          <= pwdata[`BFD_RF2_BIT];     // R09
            driver.first_driver_rf_on           <= pwdata[`BFD_RF1_BIT];     // R10
        end
    end

    // Transmit coder: serialises bytes LSB first, one bit per tick
    always_comb
    begin
        if (frame.tx_final_byte_bit_count == 3'h0)
        begin
            final_bits = `BFD_FULL_BYTE_BITS;                             // R03
        end
        else
        begin
            final_bits = {1'b0, frame.tx_final_byte_bit_count};           // R03
        end
    end

    assign tx_byte_ready = (tx_state == BFD_TX_IDLE);
    assign tx_end = (tx_state == BFD_TX_SHIFT) && tx_bit_tick &&
                    (bits_left == 4'h1) && last_byte;

    always_comb
    begin
        next_tx_state = tx_state;
        case (tx_state)
            BFD_TX_IDLE:
            begin
                if (tx_byte.valid)
                begin
                    next_tx_state = BFD_TX_SHIFT;
                end
            end
            BFD_TX_SHIFT:
            begin
                if (tx_bit_tick && (bits_left == 4'h1))
                begin
                    next_tx_state = BFD_TX_IDLE;
                end
            end
            default:
            begin
                next_tx_state = BFD_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state <= BFD_TX_IDLE;
        end
        else
        begin
            tx_state <= next_tx_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift     <= 8'h00;
            bits_left <= 4'h0;
        end
        else if (tx_state == BFD_TX_IDLE)
        begin
            if (tx_byte.valid)
            begin
                shift     <= tx_byte.data;
                bits_left <= tx_byte.last ? final_bits : `BFD_FULL_BYTE_BITS; // R03
            end
        end
        else if (tx_bit_tick)
        begin
            shift     <= {1'b0, shift[7:1]};
            bits_left <= bits_left - 4'h1;
        end
    end

    // Only the final byte of a frame is cut short and clears the field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_byte <= 1'b0;
        end
        else if ((tx_state == BFD_TX_IDLE) && tx_byte.valid)
        begin
            last_byte <= tx_byte.last;
        end
    end

    // Coder output falls back low between bytes so an idle coder never pauses the carrier
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coder_bit <= 1'b0;
        end
        else if (tx_state == BFD_TX_IDLE)
        begin
            coder_bit <= 1'b0;
        end
        else if (tx_bit_tick)
        begin
            coder_bit <= shift[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_done <= 1'b0;
        end
        else
        begin
            tx_done <= tx_end;                                            // R04
        end
    end

    // Receive side: bits are placed into FIFO bytes by the placer
    bfd_bit_placer u_placer (
        .pclk    (pclk),
        .presetn (presetn),
        .align   (frame.rx_first_bit_position),                           // R01
        .rx_in   (rx_bit),
        .fifo_wr (fifo_wr),
        .done    (rx_clear)
    );

    assign rx_done = rx_clear;

    // Modulator input: a high level suppresses the carrier (pause)
    always_comb
    begin
        case (driver.modulation_input_select)                             // R06
            BFD_MOD_LOW:      mod_in = 1'b0;
            BFD_MOD_HIGH:     mod_in = 1'b1;
            BFD_MOD_CODER:    mod_in = coder_bit;
            BFD_MOD_EXTERNAL: mod_in = external_modulation_pin;
            default:          mod_in = 1'b0;
        endcase
    end

    always_comb
    begin
        rf_burst = carrier_in && !mod_in;
        if (driver.second_driver_steady_carrier)
        begin
            second_base = carrier_in;                                     // R08
        end
        else
        begin
            second_base = rf_burst;                                       // R08
        end
    end

    // Driver outputs are registered, so they lag the carrier input by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_antenna_driver <= `BFD_IDLE_LEVEL;
        end
        else if (driver.first_driver_rf_on)
        begin
            first_antenna_driver <= rf_burst;                             // R10
        end
        else
        begin
            first_antenna_driver <= `BFD_IDLE_LEVEL;                      // R10
        end
    end

    // Invert acts only while the second driver is on; off means a constant level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_antenna_driver <= `BFD_IDLE_LEVEL;
        end
        else if (!driver.second_driver_rf_on)
        begin
            second_antenna_driver <= `BFD_IDLE_LEVEL;                     // R09
        end
        else if (driver.second_driver_invert)
        begin
            second_antenna_driver <= !second_base;                        // R07
        end
        else
        begin
            second_antenna_driver <= second_base;                         // R09
        end
    end

endmodule : bfd_top

// [verif/bfd_card_model.sv]
// Behavioural card answering with a bit frame on the receive path
`timescale 1ns/1ps
module bfd_card_model (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            go,
    input  wire logic            fast,
    input  wire logic [7:0]      bits,
    input  wire logic [3:0]      len,
    output bfd_pkg::bfd_rx_bit_t rx_bit,
    output logic                 busy
);
    import bfd_pkg::*;
    logic [7:0] sh;
    logic [3:0] left;
    logic [1:0] gap;

    // Idle data shows the inverse level so a stale bit is never taken for a fresh one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh     <= 8'h00;
            left   <= 4'h0;
            gap    <= 2'h0;
            rx_bit <= '0;
            busy   <= 1'b0;
        end
        else if (go)
        begin
            sh   <= bits;
            left <= len;
            busy <= 1'b1;
        end
        else if (left != 4'h0 && gap == 2'h0)
        begin
            rx_bit <= '{1'b1, sh[0], left == 4'h1};
            sh     <= sh >> 1;
            left   <= left - 4'h1;
            gap    <= fast ? 2'h0 : 2'h2;
        end
        else
        begin
            rx_bit <= '{1'b0, ~rx_bit.data, 1'b0};
            gap    <= (gap != 2'h0) ? gap - 2'h1 : 2'h0;
            busy   <= left != 4'h0;
        end
    end
endmodule : bfd_card_model

// [verif/bfd_checker.sv]
// Port-level assertions for the framing/driver block
`timescale 1ns/1ps
module bfd_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        carrier_in,
    input wire logic        first_antenna_driver,
    input wire logic        second_antenna_driver
);
    logic [7:0] shadow;
    logic       acc;
    logic       mapped;
    assign acc    = psel && penable;
    assign mapped = paddr == 32'h3c || paddr == 32'h44;

    // Mirror of the driver register so pin levels can be predicted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shadow <= 8'h58;
        else if (acc && pwrite && paddr == 32'h44)
            shadow <= pwdata[7:0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Settled inputs only, so one or two stages before the pins both hold
    sequence s_quiet;
        $stable(shadow) && $stable(carrier_in);
    endsequence
    sequence s_frame_read;
        psel && !penable && !pwrite && paddr == 32'h3c ##1 acc;
    endsequence

    a_unmapped_refused: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");
    a_mapped_taken: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_frame_reserved_zero: assert property (s_frame_read |->
        prdata[31:8] == 0 && !prdata[7] && !prdata[3])
        else $error("framing reserved bits set");
    a_first_held_low: assert property (s_quiet ##0 !shadow[0] |=> !first_antenna_driver)
        else $error("first driver active while off");
    a_second_held_low: assert property (s_quiet ##0 !shadow[1] |=> !second_antenna_driver)
        else $error("second driver active while off");
    a_first_carrier: assert property (s_quiet ##0 (shadow[0] && shadow[6:5] == 2'b00)
        |=> first_antenna_driver == $past(carrier_in))
        else $error("first driver not carrier");
    a_first_paused: assert property (s_quiet ##0 (shadow[0] && shadow[6:5] == 2'b01)
        |=> !first_antenna_driver)
        else $error("first driver not paused");
    a_second_steady: assert property (s_quiet ##0 (shadow[3:1] == 3'b011)
        |=> second_antenna_driver == $past(carrier_in))
        else $error("second driver not steady");
    a_second_inverted: assert property (s_quiet ##0
        (shadow[3:1] == 3'b101 && shadow[6:5] == 2'b00)
        |=> second_antenna_driver != $past(carrier_in))
        else $error("second driver not inverted");
endmodule : bfd_checker

bind bfd_top bfd_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .carrier_in(carrier_in), .first_antenna_driver(first_antenna_driver),
    .second_antenna_driver(second_antenna_driver));

// [verif/testbench.sv]
// Self-checking bench for the framing/driver block
`timescale 1ns/1ps
module testbench;
    import bfd_pkg::*;
    localparam logic [15:0] NIBS = 16'hf6a5;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [31:0]  paddr = '0, pwdata = '0, prdata, rd;
    logic         pready, pslverr, tx_byte_ready, tx_done, rx_done, drv1, drv2, busy;
    logic         tx_bit_tick = 0, carrier_in = 0, ext_pin = 0, go = 0, fast = 0;
    logic [7:0]   bits = '0;
    logic [3:0]   len = '0;
    bfd_tx_byte_t tx_byte = '0;
    bfd_rx_bit_t  rx_bit;
    bfd_fifo_wr_t fifo_wr;
    int           mismatches = 0, cmp_count = 0, rx_dones = 0;
    int           got[$], exp_q[$];

    bfd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready),
        .tx_bit_tick(tx_bit_tick), .tx_done(tx_done), .rx_bit(rx_bit), .fifo_wr(fifo_wr),
        .rx_done(rx_done), .carrier_in(carrier_in), .external_modulation_pin(ext_pin),
        .first_antenna_driver(drv1), .second_antenna_driver(drv2));
    bfd_card_model card_u (.pclk(pclk), .presetn(presetn), .go(go), .fast(fast), .bits(bits),
        .len(len), .rx_bit(rx_bit), .busy(busy));

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    always @(negedge pclk)
    begin
        if (fifo_wr.valid === 1'b1)
            got.push_back(fifo_wr.data);
        if (rx_done === 1'b1)
            rx_dones++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    initial
    begin
        #100000;
        mismatches++;
        summarize();
    end

    initial
    begin
        int k, n, al, pos, cur, have, b, d;
        logic c, e, m, w;
        logic [7:0] cfg;
        k = $urandom(32'h51fe);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 32'h3c, 32'h0);
        chk("frame reset", rd, 32'h0);
        apb(1'b0, 32'h44, 32'h0);
        chk("driver reset", rd, 32'h58);
        apb(1'b1, 32'h40, 32'hff);
        chk("unmapped write error", err, 1'b1);
        apb(1'b0, 32'h1000_003c, 32'h0);
        chk("unmapped read", {rd[30:0], err}, 32'h1);
        apb(1'b1, 32'h3c, 32'hff);
        apb(1'b0, 32'h3c, 32'h0);
        chk("frame readback", rd, 32'h77);
        for (al = 0; al < 8; al++)
        begin
            apb(1'b1, 32'h3c, al << 4);
            got.delete();
            b = $urandom % 256;
            n = 1 + $urandom % 8;
            go <= 1'b1;
            bits <= 8'(b);
            len <= 4'(n);
            fast <= al[0];
            @(posedge pclk);
            go <= 1'b0;
            do @(posedge pclk); while (busy === 1'b1);
            repeat (3) @(posedge pclk);
            exp_q.delete();
            pos = al;
            cur = 0;
            have = 0;
            for (k = 0; k < n; k++)
            begin
                cur |= ((b >> k) & 1) << pos;
                have = 1;
                pos++;
                if (pos == 8)
                begin
                    exp_q.push_back(cur);
                    cur = 0;
                    pos = 0;
                    have = 0;
                end
            end
            if (have)
                exp_q.push_back(cur);
            chk("rx byte count", got.size(), exp_q.size());
            foreach (exp_q[i]) chk("rx byte", got[i], exp_q[i]);
            apb(1'b0, 32'h3c, 32'h0);
            chk("align cleared", rd[6:4], 3'h0);
        end
        chk("rx done count", rx_dones, 8);
        apb(1'b1, 32'h44, 32'h51);
        carrier_in <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            apb(1'b1, 32'h3c, k);
            b = $urandom % 256;
            tx_byte <= '{1'b1, 8'(b), 1'b1};
            do @(posedge pclk); while (tx_byte_ready !== 1'b1);
            tx_byte.valid <= 1'b0;
            n = 0;
            d = 0;
            while (d == 0 && n < 12)
            begin
                @(posedge pclk);
                tx_bit_tick <= 1'b1;
                n++;
                @(posedge pclk);
                tx_bit_tick <= 1'b0;
                #1 d = (tx_done === 1'b1);
                @(posedge pclk);
                #1 d = d | (tx_done === 1'b1);
                chk("coder bit", drv1, ((b >> (n - 1)) & 1) ^ 1);
            end
            chk("tx bits sent", n, (k == 0) ? 8 : k);
            apb(1'b0, 32'h3c, 32'h0);
            chk("last bits cleared", rd[2:0], 3'h0);
        end
        for (k = 0; k < 16; k++)
        begin
            cfg = {1'b0, 2'(k % 4), 1'b1, NIBS[4 * (k / 4) +: 4]};
            apb(1'b1, 32'h44, cfg);
            apb(1'b0, 32'h44, 32'h0);
            chk("driver readback", rd, cfg);
            repeat (6)
            begin
                c = $urandom;
                e = $urandom;
                @(posedge pclk);
                carrier_in <= c;
                ext_pin <= e;
                repeat (2) @(posedge pclk);
                #1 m = (k % 4 == 0) ? 1'b0 : (k % 4 == 1) ? 1'b1 : e;
                if (k % 4 != 2)
                    chk("first driver", drv1, cfg[0] & c & ~m);
                w = cfg[1] & ((cfg[2] ? c : c & ~m) ^ cfg[3]);
                if (k % 4 != 2 && !(cfg[3] && m && !cfg[2]))
                    chk("second driver", drv2, w);
            end
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 32'h44, 32'h0);
        chk("driver after reset", rd, 32'h58);
        summarize();
    end
endmodule : testbench
